// ### bench/testbench.sv
// file: self-checking bench for the identification and capability rom
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import id_rom_pkg::*;
    // ==========================================================
    // content chosen so that neighbouring one-bit fields differ
    localparam logic [7:0] P_TYPE = 8'h0c;
    localparam logic [1:0] P_PWR = 2'h2;
    localparam logic [4:0] P_SUP = 5'h16;
    localparam logic [7:0] P_TEMP = 8'h46;
    localparam logic [7:0] P_MINR = 8'h0a;
    localparam logic [7:0] P_MAXR = 8'h32;
    localparam logic [15:0] P_WL = 16'h4268;
    localparam logic [15:0] P_TOL = 16'h0fa0;
    localparam logic [3:0] P_FLG = 4'h9;
    localparam logic [3:0] P_TMON = 4'h6;
    localparam logic [3:0] P_VMON = 4'hb;
    localparam logic P_TXCDR = 1'b1;
    localparam logic P_RXCDR = 1'b0;
    localparam logic P_REFCLK = 1'b1;
    localparam logic P_PAGE2 = 1'b0;
    localparam logic P_LAUNCH = 1'b1;
    localparam logic P_SQL = 1'b1;
    localparam logic P_AW = 1'b0;
    localparam logic P_BIAS = 1'b1;
    localparam logic P_OPWR = 1'b0;
    localparam logic P_PERCH = 1'b1;
    localparam logic P_AVG = 1'b0;
    localparam logic P_BER = 1'b0;
    localparam logic P_COOL = 1'b1;
    // expected bytes laid out bit by bit as the rules place the fields
    localparam logic [7:0] E_DESC = {P_PWR, P_TXCDR, P_RXCDR, P_REFCLK, P_PAGE2, P_LAUNCH, 1'b0};
    localparam logic [7:0] E_FLG = {P_FLG, P_SQL, P_AW, 2'b00};
    localparam logic [7:0] E_MONA = {P_BIAS, P_OPWR, P_PERCH, P_AVG, P_TMON};
    localparam logic [7:0] E_MONB = {P_BER, P_VMON, P_COOL, 2'b00};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    axil_req_t req = '0;
    axil_rsp_t rsp;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int resp_lag = 0;
    always #2.5 aclk = ~aclk;
    module_id_capability_rom #(.MODULE_TYPE(P_TYPE), .POWER_CLASS(P_PWR), .TX_CDR(P_TXCDR),
        .RX_CDR(P_RXCDR), .REF_CLK_REQ(P_REFCLK), .PAGE2(P_PAGE2), .CTRL_LAUNCH(P_LAUNCH),
        .SUPPLIES(P_SUP), .MAX_CASE_TEMP(P_TEMP), .MIN_RATE(P_MINR), .MAX_RATE(P_MAXR),
        .WAVELENGTH(P_WL), .WL_TOLERANCE(P_TOL), .FLAGS_PROVIDED(P_FLG),
        .SQUELCH_ON_LOSS(P_SQL), .ALARM_AND_WARNING(P_AW), .TX_BIAS_MON(P_BIAS),
        .OUTPUT_POWER_MONITOR(P_OPWR), .PER_CHANNEL_RX_MON(P_PERCH),
        .AVG_POWER_REPORT(P_AVG), .TEMP_MONITORS(P_TMON), .BIT_ERROR_RATE_MON(P_BER),
        .SUPPLY_MONITORS(P_VMON), .COOLER_CURRENT_MON(P_COOL)
    ) dut (.aclk(aclk), .aresetn(aresetn), .s_req(req), .s_rsp(rsp));
    // ==========================================================
    // verdict and hang guard
    task automatic stop_test();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : check
    // ==========================================================
    // bus master: address and data offered together, held until taken
    // resp_lag above zero raises the response ready that many edges late
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= (resp_lag == 0);
        forever begin
            @(posedge aclk);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid && req.bready) begin
                r = rsp.bresp;
                req.bready <= 1'b0;
                break;
            end
            if (n == resp_lag) req.bready <= 1'b1;
        end
    endtask : axi_write
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= (resp_lag == 0);
        forever begin
            @(posedge aclk);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid && req.rready) begin
                d = rsp.rdata;
                r = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
            if (n == resp_lag) req.rready <= 1'b1;
        end
    endtask : axi_read
    task automatic rd_expect(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check($sformatf("rdata@%h", a), exp, d);
        check($sformatf("rresp@%h", a), {30'h0, er}, {30'h0, r});
    endtask : rd_expect
    task automatic wr_expect(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        axi_write(a, d, r);
        check($sformatf("bresp@%h", a), {30'h0, er}, {30'h0, r});
    endtask : wr_expect
    // ==========================================================
    // scenarios
    task automatic test_reset();
        check("readies", 32'h7, {29'h0, rsp.awready, rsp.wready, rsp.arready});
        check("valids", 32'h0, {30'h0, rsp.bvalid, rsp.rvalid});
    endtask : test_reset
    task automatic test_contents();
        rd_expect(12'h200, {24'h0, P_TYPE}, RESP_OKAY);
        rd_expect(12'h204, {24'h0, E_DESC}, RESP_OKAY);
        rd_expect(12'h208, {24'h0, P_SUP, 3'b000}, RESP_OKAY);
        rd_expect(12'h20c, {24'h0, P_TEMP}, RESP_OKAY);
        rd_expect(12'h210, {24'h0, P_MINR}, RESP_OKAY);
        rd_expect(12'h214, {24'h0, P_MAXR}, RESP_OKAY);
        rd_expect(12'h218, {16'h0, P_WL}, RESP_OKAY);
        rd_expect(12'h220, {16'h0, P_TOL}, RESP_OKAY);
        rd_expect(12'h228, {24'h0, E_FLG}, RESP_OKAY);
        rd_expect(12'h22c, {24'h0, E_MONA}, RESP_OKAY);
        rd_expect(12'h230, {24'h0, E_MONB}, RESP_OKAY);
    endtask : test_contents
    task automatic test_write_ignored();
        wr_expect(12'h200, 32'hffff_ffff, RESP_OKAY);
        rd_expect(12'h200, {24'h0, P_TYPE}, RESP_OKAY);
        wr_expect(12'h218, 32'h0000_0000, RESP_OKAY);
        rd_expect(12'h218, {16'h0, P_WL}, RESP_OKAY);
        rd_expect(12'h1f8, 32'h1, RESP_OKAY);
        wr_expect(12'h1f8, 32'h1, RESP_OKAY);
        rd_expect(12'h1f8, 32'h0, RESP_OKAY);
    endtask : test_write_ignored
    task automatic test_page();
        wr_expect(12'h1fc, 32'h01, RESP_OKAY);
        rd_expect(12'h1fc, 32'h01, RESP_OKAY);
        rd_expect(12'h22c, 32'h0, RESP_SLVERR);
        wr_expect(12'h1fc, 32'h00, RESP_OKAY);
        rd_expect(12'h22c, {24'h0, 4'b1010, P_TMON}, RESP_OKAY);
    endtask : test_page
    task automatic test_unmapped();
        rd_expect(12'h21c, 32'h0, RESP_DECERR);
        wr_expect(12'h224, 32'h5a, RESP_DECERR);
        rd_expect(12'h234, 32'h0, RESP_DECERR);
        rd_expect(12'h1f8, 32'h2, RESP_OKAY);
        wr_expect(12'h1f8, 32'h2, RESP_OKAY);
        rd_expect(12'h1f8, 32'h0, RESP_OKAY);
        rd_expect(12'h220, {16'h0, P_TOL}, RESP_OKAY);
    endtask : test_unmapped
    // answers must stand while the master holds its ready low
    task automatic test_backpressure();
        resp_lag = 3;
        rd_expect(12'h22c, {24'h0, E_MONA}, RESP_OKAY);
        wr_expect(12'h204, 32'h0000_0000, RESP_OKAY);
        rd_expect(12'h204, {24'h0, E_DESC}, RESP_OKAY);
        resp_lag = 0;
    endtask : test_backpressure
    // reset in mid-run returns page select and status flags to zero
    task automatic test_midreset();
        wr_expect(12'h1fc, 32'h01, RESP_OKAY);
        wr_expect(12'h200, 32'h00, RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        test_reset();
        rd_expect(12'h1fc, 32'h00, RESP_OKAY);
        rd_expect(12'h1f8, 32'h00, RESP_OKAY);
        rd_expect(12'h200, {24'h0, P_TYPE}, RESP_OKAY);
    endtask : test_midreset
    // ==========================================================
    // main sequence: reset for three cycles, then every scenario
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        test_reset();
        test_contents();
        test_write_ignored();
        test_page();
        test_unmapped();
        test_backpressure();
        test_midreset();
        stop_test();
    end
endmodule : testbench
`default_nettype wire

// ### design/id_rom_pkg.sv
// package: indices, field layout, bus carriers and state for the id rom
//
// Summary of operation
// - byte 128 module type, zero when unspecified
// - byte 129 bits 7-6 power class code
// - byte 129 bits 5/4 transmit/receive clock recovery
// - byte 129 refclk, page 02, launch; bit 0 reserved
// - byte 130 required supply flags; bits 2-0 reserved
// - byte 131 maximum case temperature, one degree
// - byte 132 minimum signal rate, 100 Mb/s units
// - byte 133 maximum signal rate, 100 Mb/s units
// - bytes 134-135 wavelength, value over 20 nm
// - bytes 136-137 tolerance, value over 200 nm
// - byte 138 status flags provided; bits 1-0 reserved
// - byte 138 squelch bit, alarm-and-warning bit
// - byte 139 transmit bias and power monitors
// - byte 139 per-channel receive monitor, average reporting
// - byte 139 temperature and elapsed time monitors
// - byte 140 error rate, supply, cooler monitors
// - id bytes appear on upper page zero
package id_rom_pkg;
    // ==========================================================
    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 10;
    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MODULE_TYPE = 10'h080;
    localparam logic [IDX_W-1:0] IDX_MODULE_DESC = 10'h081;
    localparam logic [IDX_W-1:0] IDX_SUPPLIES = 10'h082;
    localparam logic [IDX_W-1:0] IDX_MAX_CASE_TEMP = 10'h083;
    localparam logic [IDX_W-1:0] IDX_MIN_RATE = 10'h084;
    localparam logic [IDX_W-1:0] IDX_MAX_RATE = 10'h085;
    localparam logic [IDX_W-1:0] IDX_WAVELENGTH = 10'h086;
    localparam logic [IDX_W-1:0] IDX_WL_TOLERANCE = 10'h088;
    localparam logic [IDX_W-1:0] IDX_FLAGS = 10'h08a;
    localparam logic [IDX_W-1:0] IDX_MONITORS_A = 10'h08b;
    localparam logic [IDX_W-1:0] IDX_MONITORS_B = 10'h08c;
    localparam logic [IDX_W-1:0] IDX_ACCESS_STATUS = 10'h07e;
    localparam logic [IDX_W-1:0] IDX_PAGE_SELECT = 10'h07f;
    localparam logic [7:0] ID_PAGE = 8'h00;
    // ==========================================================
    // field positions
    localparam int PWR_MSB = 7;
    localparam int PWR_LSB = 6;
    localparam int TX_CDR_BIT = 5;
    localparam int RX_CDR_BIT = 4;
    localparam int REFCLK_BIT = 3;
    localparam int PAGE2_BIT = 2;
    localparam int LAUNCH_BIT = 1;
    localparam int DESC_RSVD_BIT = 0;
    localparam int SUP_MSB = 7;
    localparam int SUP_LSB = 3;
    localparam int SUP_RSVD_MSB = 2;
    localparam int FLG_MSB = 7;
    localparam int FLG_LSB = 4;
    localparam int SQUELCH_BIT = 3;
    localparam int ALARM_WARN_BIT = 2;
    localparam int FLG_RSVD_MSB = 1;
    localparam int TX_BIAS_BIT = 7;
    localparam int OUT_PWR_BIT = 6;
    localparam int PER_CH_BIT = 5;
    localparam int AVG_PWR_BIT = 4;
    localparam int TEMP_MSB = 3;
    localparam int BER_BIT = 7;
    localparam int VMON_MSB = 6;
    localparam int VMON_LSB = 3;
    localparam int COOLER_BIT = 2;
    localparam int MONB_RSVD_MSB = 1;
    localparam int STAT_IGN_WR_BIT = 0;
    localparam int STAT_BAD_ADDR_BIT = 1;
    // ==========================================================
    // response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // ==========================================================
    // carriers and state
    typedef enum logic {WR_COLLECT = 1'b0, WR_RESP = 1'b1} wr_state_t;
    typedef enum logic {RD_IDLE = 1'b0, RD_RESP = 1'b1} rd_state_t;
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic [2:0] awprot;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic [2:0] arprot;
        logic rready;
    } axil_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;
    typedef struct packed {
        wr_state_t wst;
        logic aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic w_held;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        rd_state_t rst;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic [7:0] page_sel;
        logic ign_wr;
        logic bad_addr;
    } state_t;
    // all zero: idle channels, page zero, flags clear
    localparam state_t STATE_RESET = '0;
endpackage : id_rom_pkg

// ### design/module_id_capability_rom.sv
// file: identification and capability bytes behind an axi4-lite slave
`timescale 1ns/10ps
`default_nettype none
module module_id_capability_rom #(
    parameter logic [7:0] MODULE_TYPE = 8'h00, // type code
    parameter logic [1:0] POWER_CLASS = 2'h0, // power class code
    parameter logic TX_CDR = 1'b0, // transmit recovery fitted
    parameter logic RX_CDR = 1'b0, // receive recovery fitted
    parameter logic REF_CLK_REQ = 1'b0, // reference clock needed
    parameter logic PAGE2 = 1'b0, // page 02 exists
    parameter logic CTRL_LAUNCH = 1'b0, // controlled launch
    parameter logic [4:0] SUPPLIES = 5'h00, // 3.3, 2.5, 1.8, vo, var
    parameter logic [7:0] MAX_CASE_TEMP = 8'h00, // degrees
    parameter logic [7:0] MIN_RATE = 8'h00, // 100 mb/s units
    parameter logic [7:0] MAX_RATE = 8'h00, // 100 mb/s units
    parameter logic [15:0] WAVELENGTH = 16'h0000, // nm times 20
    parameter logic [15:0] WL_TOLERANCE = 16'h0000, // nm times 200
    parameter logic [3:0] FLAGS_PROVIDED = 4'h0, // fault, losses, lock
    parameter logic SQUELCH_ON_LOSS = 1'b0, // squelch on loss
    parameter logic ALARM_AND_WARNING = 1'b0, // warnings as well
    parameter logic TX_BIAS_MON = 1'b0, // bias monitor
    parameter logic OUTPUT_POWER_MONITOR = 1'b0, // tx power
    parameter logic PER_CHANNEL_RX_MON = 1'b0, // per channel
    parameter logic AVG_POWER_REPORT = 1'b0, // average, not amplitude
    parameter logic [3:0] TEMP_MONITORS = 4'h0, // case, int, peak, time
    parameter logic BIT_ERROR_RATE_MON = 1'b0, // error rate
    parameter logic [3:0] SUPPLY_MONITORS = 4'h0, // internal rails
    parameter logic COOLER_CURRENT_MON = 1'b0 // cooler current
) (
    input wire logic aclk, // bus clock, 200 mhz
    input wire logic aresetn, // synchronous reset, low
    input wire id_rom_pkg::axil_req_t s_req, // master channels
    output var id_rom_pkg::axil_rsp_t s_rsp // slave channels
);
    import id_rom_pkg::*;

    // ==========================================================
    // content bytes, fixed at build time
    localparam logic [7:0] DESC_BYTE = {POWER_CLASS, TX_CDR, RX_CDR,
        REF_CLK_REQ, PAGE2, CTRL_LAUNCH, 1'b0};
    localparam logic [7:0] SUP_BYTE = {SUPPLIES, 3'h0};
    localparam logic [7:0] FLG_BYTE = {FLAGS_PROVIDED, SQUELCH_ON_LOSS,
        ALARM_AND_WARNING, 2'h0};
    localparam logic [7:0] MONA_BYTE = {TX_BIAS_MON,
        OUTPUT_POWER_MONITOR, PER_CHANNEL_RX_MON, AVG_POWER_REPORT,
        TEMP_MONITORS};
    localparam logic [7:0] MONB_BYTE = {BIT_ERROR_RATE_MON,
        SUPPLY_MONITORS, COOLER_CURRENT_MON, 2'h0};
    localparam int N_ID = 11;

    state_t st_ff;
    state_t nxt_ff;
    logic [N_ID-1:0][IDX_W-1:0] id_keys;
    logic [N_ID-1:0][15:0] id_vals;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_commit;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic [IDX_W-1:0] wr_key;
    logic [IDX_W-1:0] rd_key;
    logic wr_id_hit;
    logic rd_id_hit;
    logic [15:0] rd_val;
    logic rd_miss;

    // ==========================================================
    // table, one entry per identification register
    assign id_keys = {IDX_MONITORS_B, IDX_MONITORS_A, IDX_FLAGS,
        IDX_WL_TOLERANCE, IDX_WAVELENGTH, IDX_MAX_RATE, IDX_MIN_RATE,
        IDX_MAX_CASE_TEMP, IDX_SUPPLIES, IDX_MODULE_DESC,
        IDX_MODULE_TYPE};
    assign id_vals = {
        {8'h00, MONB_BYTE},
        {8'h00, MONA_BYTE},
        {8'h00, FLG_BYTE},
        WL_TOLERANCE,
        WAVELENGTH,
        {8'h00, MAX_RATE},
        {8'h00, MIN_RATE},
        {8'h00, MAX_CASE_TEMP},
        {8'h00, SUP_BYTE},
        {8'h00, DESC_BYTE},
        {8'h00, MODULE_TYPE}
    };

    // ==========================================================
    // channel handshakes and write operand selection
    assign aw_fire = s_req.awvalid && s_rsp.awready;
    assign w_fire = s_req.wvalid && s_rsp.wready;
    assign ar_fire = s_req.arvalid && s_rsp.arready;
    assign wr_commit = (st_ff.wst == WR_COLLECT) &&
        (st_ff.aw_held || aw_fire) && (st_ff.w_held || w_fire);
    assign wr_addr = st_ff.aw_held ? st_ff.awaddr : s_req.awaddr;
    assign wr_data = st_ff.w_held ? st_ff.wdata : s_req.wdata;
    assign wr_strb = st_ff.w_held ? st_ff.wstrb : s_req.wstrb;
    assign wr_key = wr_addr[ADDR_W-1:2];
    assign rd_key = s_req.araddr[ADDR_W-1:2];
    assign rd_miss = !rd_id_hit && (rd_key != IDX_PAGE_SELECT) &&
        (rd_key != IDX_ACCESS_STATUS);

    // lookup for the read side
    ro_lookup #(.N(N_ID), .KW(IDX_W), .DW(16)) u_rd_lookup (
        .key(rd_key),
        .keys(id_keys),
        .vals(id_vals),
        .hit(rd_id_hit),
        .data(rd_val)
    );

    // lookup for the write side, only the hit is needed
    ro_lookup #(.N(N_ID), .KW(IDX_W), .DW(16)) u_wr_lookup (
        .key(wr_key),
        .keys(id_keys),
        .vals(id_vals),
        .hit(wr_id_hit),
        .data()
    );

    // ==========================================================
    // next state: write path first, read path last so its set wins
    always_comb begin
        nxt_ff = st_ff;
        if (aw_fire) begin
            nxt_ff.aw_held = 1'b1;
            nxt_ff.awaddr = s_req.awaddr;
        end
        if (w_fire) begin
            nxt_ff.w_held = 1'b1;
            nxt_ff.wdata = s_req.wdata;
            nxt_ff.wstrb = s_req.wstrb;
        end
        if (wr_commit) begin
            nxt_ff.wst = WR_RESP;
            nxt_ff.aw_held = 1'b0;
            nxt_ff.w_held = 1'b0;
            nxt_ff.bresp = RESP_OKAY;
            if (wr_id_hit) begin
                nxt_ff.ign_wr = 1'b1;
            end else if (wr_key == IDX_PAGE_SELECT) begin
                if (wr_strb[0]) begin
                    nxt_ff.page_sel = wr_data[7:0];
                end
            end else if (wr_key == IDX_ACCESS_STATUS) begin
                if (wr_strb[0]) begin
                    nxt_ff.ign_wr = st_ff.ign_wr & ~wr_data[STAT_IGN_WR_BIT];
                    nxt_ff.bad_addr = st_ff.bad_addr &
                        ~wr_data[STAT_BAD_ADDR_BIT];
                end
            end else begin
                nxt_ff.bresp = RESP_DECERR;
                nxt_ff.bad_addr = 1'b1;
            end
        end
        if (st_ff.wst == WR_RESP && s_req.bready) begin
            nxt_ff.wst = WR_COLLECT;
        end
        if (ar_fire) begin
            nxt_ff.rst = RD_RESP;
            nxt_ff.rresp = RESP_OKAY;
            nxt_ff.rdata = '0;
            if (rd_id_hit) begin
                if (st_ff.page_sel == ID_PAGE) begin
                    nxt_ff.rdata = {16'h0000, rd_val};
                end else begin
                    nxt_ff.rresp = RESP_SLVERR;
                end
            end else if (rd_key == IDX_PAGE_SELECT) begin
                nxt_ff.rdata = {24'h000000, st_ff.page_sel};
            end else if (rd_key == IDX_ACCESS_STATUS) begin
                nxt_ff.rdata[STAT_IGN_WR_BIT] = st_ff.ign_wr;
                nxt_ff.rdata[STAT_BAD_ADDR_BIT] = st_ff.bad_addr;
            end else begin
                nxt_ff.rresp = RESP_DECERR;
                nxt_ff.bad_addr = 1'b1;
            end
        end
        if (st_ff.rst == RD_RESP && s_req.rready) begin
            nxt_ff.rst = RD_IDLE;
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= STATE_RESET;
        end else begin
            st_ff <= nxt_ff;
        end
    end

    // ==========================================================
    // slave outputs: readies from state, payloads from flops
    always_comb begin
        s_rsp.awready = (st_ff.wst == WR_COLLECT) && !st_ff.aw_held;
        s_rsp.wready = (st_ff.wst == WR_COLLECT) && !st_ff.w_held;
        s_rsp.bvalid = (st_ff.wst == WR_RESP);
        s_rsp.bresp = st_ff.bresp;
        s_rsp.arready = (st_ff.rst == RD_IDLE);
        s_rsp.rvalid = (st_ff.rst == RD_RESP);
        s_rsp.rdata = st_ff.rdata;
        s_rsp.rresp = st_ff.rresp;
    end

    // ==========================================================
    // checks on the returned contents and the bus answers
    logic id_rd;
    assign id_rd = ar_fire && rd_id_hit && (st_ff.page_sel == ID_PAGE);

    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    type_byte_a: assert property (
        id_rd && rd_key == IDX_MODULE_TYPE |=> s_rsp.rvalid &&
        s_rsp.rdata == {24'h000000, MODULE_TYPE})
        else $error("module type byte wrong");
    power_class_a: assert property (
        id_rd && rd_key == IDX_MODULE_DESC |=>
        s_rsp.rdata[PWR_MSB:PWR_LSB] == POWER_CLASS)
        else $error("power class wrong");
    recovery_bits_a: assert property (
        id_rd && rd_key == IDX_MODULE_DESC |=>
        s_rsp.rdata[TX_CDR_BIT] == TX_CDR &&
        s_rsp.rdata[RX_CDR_BIT] == RX_CDR)
        else $error("clock recovery bits wrong");
    desc_low_a: assert property (
        id_rd && rd_key == IDX_MODULE_DESC |=>
        s_rsp.rdata[REFCLK_BIT] == REF_CLK_REQ &&
        s_rsp.rdata[PAGE2_BIT] == PAGE2 &&
        s_rsp.rdata[LAUNCH_BIT] == CTRL_LAUNCH &&
        !s_rsp.rdata[DESC_RSVD_BIT])
        else $error("description low bits wrong");
    supplies_a: assert property (
        id_rd && rd_key == IDX_SUPPLIES |=>
        s_rsp.rdata[SUP_MSB:SUP_LSB] == SUPPLIES &&
        s_rsp.rdata[SUP_RSVD_MSB:0] == 3'h0)
        else $error("supply byte wrong");
    case_temp_a: assert property (
        id_rd && rd_key == IDX_MAX_CASE_TEMP |=>
        s_rsp.rdata == {24'h000000, MAX_CASE_TEMP})
        else $error("case temperature wrong");
    min_rate_a: assert property (
        id_rd && rd_key == IDX_MIN_RATE |=>
        s_rsp.rdata == {24'h000000, MIN_RATE})
        else $error("minimum rate wrong");
    max_rate_a: assert property (
        id_rd && rd_key == IDX_MAX_RATE |=>
        s_rsp.rdata == {24'h000000, MAX_RATE})
        else $error("maximum rate wrong");
    wavelength_a: assert property (
        id_rd && rd_key == IDX_WAVELENGTH |=>
        s_rsp.rdata == {16'h0000, WAVELENGTH})
        else $error("wavelength wrong");
    tolerance_a: assert property (
        id_rd && rd_key == IDX_WL_TOLERANCE |=>
        s_rsp.rdata == {16'h0000, WL_TOLERANCE})
        else $error("tolerance wrong");
    flag_bits_a: assert property (
        id_rd && rd_key == IDX_FLAGS |=>
        s_rsp.rdata[FLG_MSB:FLG_LSB] == FLAGS_PROVIDED &&
        s_rsp.rdata[FLG_RSVD_MSB:0] == 2'h0)
        else $error("flag byte wrong");
    squelch_alarm_a: assert property (
        id_rd && rd_key == IDX_FLAGS |=>
        s_rsp.rdata[SQUELCH_BIT] == SQUELCH_ON_LOSS &&
        s_rsp.rdata[ALARM_WARN_BIT] == ALARM_AND_WARNING)
        else $error("squelch or alarm bit wrong");
    tx_monitors_a: assert property (
        id_rd && rd_key == IDX_MONITORS_A |=>
        s_rsp.rdata[TX_BIAS_BIT] == TX_BIAS_MON &&
        s_rsp.rdata[OUT_PWR_BIT] == OUTPUT_POWER_MONITOR)
        else $error("transmit monitor bits wrong");
    rx_report_a: assert property (
        id_rd && rd_key == IDX_MONITORS_A |=>
        s_rsp.rdata[PER_CH_BIT] == PER_CHANNEL_RX_MON &&
        s_rsp.rdata[AVG_PWR_BIT] == AVG_POWER_REPORT)
        else $error("receive report bits wrong");
    temp_monitors_a: assert property (
        id_rd && rd_key == IDX_MONITORS_A |=>
        s_rsp.rdata[TEMP_MSB:0] == TEMP_MONITORS)
        else $error("temperature monitor bits wrong");
    monitors_b_a: assert property (
        id_rd && rd_key == IDX_MONITORS_B |=>
        s_rsp.rdata[BER_BIT] == BIT_ERROR_RATE_MON &&
        s_rsp.rdata[VMON_MSB:VMON_LSB] == SUPPLY_MONITORS &&
        s_rsp.rdata[COOLER_BIT] == COOLER_CURRENT_MON &&
        s_rsp.rdata[MONB_RSVD_MSB:0] == 2'h0)
        else $error("second monitor byte wrong");
    page_gate_a: assert property (
        ar_fire && rd_id_hit && st_ff.page_sel != ID_PAGE |=>
        s_rsp.rvalid && s_rsp.rresp == RESP_SLVERR &&
        s_rsp.rdata == 32'h00000000)
        else $error("id byte visible off page zero");
    write_ignored_a: assert property (
        wr_commit && wr_id_hit |=> s_rsp.bvalid &&
        s_rsp.bresp == RESP_OKAY && st_ff.ign_wr &&
        $stable(st_ff.page_sel))
        else $error("id write not ignored");
    bresp_hold_a: assert property (
        s_rsp.bvalid && !s_req.bready |=>
        s_rsp.bvalid && $stable(s_rsp.bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (
        s_rsp.rvalid && !s_req.rready |=>
        s_rsp.rvalid && $stable(s_rsp.rdata))
        else $error("read response dropped");
    miss_sets_a: assert property (
        ar_fire && rd_miss |=> st_ff.bad_addr &&
        s_rsp.rresp == RESP_DECERR)
        else $error("unmapped read not flagged");

    // unmapped writes answer decode error and raise the status bit
    logic wr_miss;
    assign wr_miss = !wr_id_hit && (wr_key != IDX_PAGE_SELECT) &&
        (wr_key != IDX_ACCESS_STATUS);
    wr_miss_a: assert property (
        wr_commit && wr_miss |=> s_rsp.bvalid &&
        s_rsp.bresp == RESP_DECERR && st_ff.bad_addr)
        else $error("unmapped write not flagged");
    page_write_a: assert property (
        wr_commit && wr_key == IDX_PAGE_SELECT && wr_strb[0] |=>
        st_ff.page_sel == $past(wr_data[7:0]))
        else $error("page select not written");
    status_clear_a: assert property (
        wr_commit && wr_key == IDX_ACCESS_STATUS && wr_strb[0] &&
        wr_data[STAT_IGN_WR_BIT] |=> !st_ff.ign_wr)
        else $error("ignored-write flag not cleared");

    read_id_c: cover property (id_rd ##1 s_rsp.rvalid && s_req.rready);
    write_ign_c: cover property (wr_commit && wr_id_hit);
    page_off_c: cover property (ar_fire && rd_id_hit &&
        st_ff.page_sel != ID_PAGE);
    split_write_c: cover property (aw_fire && !w_fire ##[1:4] w_fire);
    resp_stall_c: cover property (s_rsp.rvalid && !s_req.rready);
endmodule : module_id_capability_rom
`default_nettype wire

// ### design/ro_lookup.sv
// file: keyed lookup of a constant content table
`timescale 1ns/10ps
`default_nettype none
module ro_lookup #(
    parameter int N = 2,
    parameter int KW = 10,
    parameter int DW = 16
) (
    input wire logic [KW-1:0] key, // index asked for
    input wire logic [N-1:0][KW-1:0] keys, // index of each entry
    input wire logic [N-1:0][DW-1:0] vals, // content of each entry
    output logic hit, // key matches an entry
    output logic [DW-1:0] data // content of matching entry
);
    // ==========================================================
    // match the key against every entry
    always_comb begin
        hit = 1'b0;
        data = '0;
        for (int i = 0; i < N; i++) begin
            if (keys[i] == key) begin
                hit = 1'b1;
                data = vals[i];
            end
        end
    end
endmodule : ro_lookup
`default_nettype wire
